// [common/compact_timer_map.svh]
// register offsets, field positions, reset values and timing constants of the compact timer
`ifndef COMPACT_TIMER_MAP_SVH
`define COMPACT_TIMER_MAP_SVH

`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_CNT_LO 8'h08
`define OFS_CNT_HI 8'h0C
`define OFS_CMPA_LO 8'h10
`define OFS_CMPA_HI 8'h14
`define OFS_PIN_SEL 8'h18
`define OFS_IN_SEL 8'h1C
`define OFS_STATUS 8'h20

`define RST_BYTE 8'h00
`define FUNC_ALT 2'h3
`define PIN_SEL_MASK 8'hCF
`define IN_SEL_MASK 8'h03
`define CNT_MAX 10'h3FF
`define CNT_ZERO 10'h000

`define F_PAUSE 7
`define F_CKS_HI 6
`define F_CKS_LO 4
`define F_RUN 3
`define F_PER_HI 2
`define F_MODE_HI 7
`define F_MODE_LO 6
`define F_IO_HI 5
`define F_IO_LO 4
`define F_INIT 3
`define F_POL 2
`define F_CLRSEL 0
`define F_P7_HI 7
`define F_P7_LO 6
`define F_P5_HI 3
`define F_P5_LO 2
`define F_P4_HI 1
`define F_P4_LO 0
`define F_CKPIN 1
`define F_IRQPIN 0

// prescale dividers for the internal ratio sources
`define DIV_SYS4 6'h03
`define DIV_H16 6'h0F
`define DIV_H64 6'h3F

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [common/compact_timer_pkg.sv]
// types shared by the compact timer design
package compact_timer_pkg;
    typedef enum logic [2:0] {
        CK_SYS_DIV4, CK_SYS, CK_H_DIV16, CK_H_DIV64, CK_SUB_A, CK_SUB_B, CK_PIN_RISE, CK_PIN_FALL
    } count_clock_select_t;
    typedef enum logic [1:0] {
        MODE_COMPARE, MODE_UNDEF, MODE_PWM, MODE_TIMER
    } timer_mode_t;
endpackage : compact_timer_pkg

// [hdl/compact_timer.sv]
// compact timer with byte-buffered counter access and pin routing, on an axi4-lite slave
//
// Behaviour
// [R1] pin7 carries timer output when field is 11
// [R2] pin-select bits 5 and 4 read zero
// [R3] pin5 goes to touch key one on 11
// [R4] pin4 goes to touch key four on 11
// [R5] ext clock from pin6, or pin0 when set
// [R6] ext irq from pin0, or pin6; upper zero
// [R7] counter equal comparator raises timer interrupt
// [R8] separate comparator A and P interrupts
// [R9] three-bit counter clock source select
// [R10] external clock pin, rising or falling edge
// [R11] compare mode drives output high, low, toggle
// [R12] pwm appears on output and inverted pin
// [R13] software selects pin function before use
// [R14] counter and compare A as byte pairs
// [R15] low write buffered, high write commits both
// [R16] high read latches low byte into buffer
// [R17] software keeps low/high access order
// [R18] 10-bit up counter with three clear causes
// [R19] period vs top three bits, A vs all
// [R20] external clock synchronised, edge detected
`timescale 1ns/1ps
`include "compact_timer_map.svh"

module compact_timer (
    input wire logic clock_i, // 200 mhz system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic high_internal_clock_tick_i, // one-cycle tick of the internal high clock
    input wire logic sub_clock_tick_i, // one-cycle tick of the sub clock
    input wire logic port_pin0_i, // level on port pin 0
    input wire logic port_pin6_i, // level on port pin 6
    output logic port_pin7_timer_sel_o, // pin 7 carries timer_out
    output logic port_pin5_key_sel_o, // pin 5 is touch_key_one
    output logic port_pin4_key_sel_o, // pin 4 is touch_key_four
    output logic ext_irq_in_o, // routed external interrupt input
    output logic timer_out_o, // primary timer output
    output logic timer_out_n_o, // inverted timer output
    output logic irq_cmp_a_o, // comparator A match pulse
    output logic irq_cmp_p_o // comparator P match or counter overflow pulse
);

    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [7:0] pin_function_select_upper_r;
    logic [7:0] input_source_select_r;
    logic [9:0] count_r;
    logic [9:0] compare_a_value_r;
    logic [7:0] byte_buf_r;
    logic [5:0] prescale_r;
    logic [2:0] ext_sync_r;
    logic run_d_r;
    logic out_r;
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic tick;
    logic ext_pin;
    logic match_a;
    logic match_p;
    logic overflow;
    logic run_rise;
    logic wr_fire;
    logic rd_fire;
    logic [2:0] period_compare_value;
    compact_timer_pkg::count_clock_select_t count_clock_select;
    compact_timer_pkg::timer_mode_t mode;

    // true when a two-bit pin field selects the alternate function
    function automatic logic is_alt(input logic [1:0] field);
        return field == `FUNC_ALT;
    endfunction : is_alt

    assign count_clock_select = compact_timer_pkg::count_clock_select_t'(ctrl0_r[`F_CKS_HI:`F_CKS_LO]);
    assign mode = compact_timer_pkg::timer_mode_t'(ctrl1_r[`F_MODE_HI:`F_MODE_LO]);
    assign period_compare_value = ctrl0_r[`F_PER_HI:0];

    // pin routing of the clock input, pin0 or pin6
    assign ext_pin = input_source_select_r[`F_CKPIN] ? port_pin0_i : port_pin6_i; // see [R5]

    // two-stage synchroniser plus one edge history stage; stage 0 feeds only stage 1
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ext_sync_r <= 3'h0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], ext_pin}; // see [R20]
        end
    end

    // free prescaler for the fractional internal sources
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prescale_r <= 6'h00;
        end else if (count_clock_select == compact_timer_pkg::CK_SYS_DIV4) begin
            prescale_r <= prescale_r + 6'h01;
        end else if (high_internal_clock_tick_i) begin
            prescale_r <= prescale_r + 6'h01;
        end
    end

    // count enable from the selected source
    always_comb begin
        case (count_clock_select) // see [R9]
            compact_timer_pkg::CK_SYS_DIV4: tick = (prescale_r[1:0] == 2'(`DIV_SYS4));
            compact_timer_pkg::CK_SYS: tick = 1'b1;
            compact_timer_pkg::CK_H_DIV16: tick = high_internal_clock_tick_i && (prescale_r[3:0] == 4'(`DIV_H16));
            compact_timer_pkg::CK_H_DIV64: tick = high_internal_clock_tick_i && (prescale_r == `DIV_H64);
            compact_timer_pkg::CK_SUB_A, compact_timer_pkg::CK_SUB_B: tick = sub_clock_tick_i;
            compact_timer_pkg::CK_PIN_RISE: tick = ext_sync_r[1] && !ext_sync_r[2]; // see [R10]
            compact_timer_pkg::CK_PIN_FALL: tick = !ext_sync_r[1] && ext_sync_r[2]; // see [R10]
            default: tick = 1'b0;
        endcase
    end

    // comparators; period 000 means full 1024-count overflow
    assign match_a = tick && (count_r == compare_a_value_r); // see [R19]
    assign match_p = tick && (period_compare_value != 3'h0)
        && (count_r[9:7] == period_compare_value) && (count_r[6:0] == 7'h00); // see [R19]
    assign overflow = tick && (count_r == `CNT_MAX);
    assign run_rise = ctrl0_r[`F_RUN] && !run_d_r;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= ctrl0_r[`F_RUN];
        end
    end

    // main 10-bit up counter; pause and off both hold the residual value
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_r <= `CNT_ZERO;
        end else if (run_rise) begin
            count_r <= `CNT_ZERO; // see [R18]
        end else if (ctrl0_r[`F_RUN] && !ctrl0_r[`F_PAUSE] && tick) begin
            if (overflow || (ctrl1_r[`F_CLRSEL] ? match_a : match_p)) begin
                count_r <= `CNT_ZERO; // see [R18]
            end else begin
                count_r <= count_r + 10'h001;
            end
        end
    end

    // interrupt pulses, one per comparator
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_cmp_a_o <= 1'b0;
            irq_cmp_p_o <= 1'b0;
        end else begin
            irq_cmp_a_o <= ctrl0_r[`F_RUN] && !ctrl0_r[`F_PAUSE] && match_a; // see [R7] [R8]
            irq_cmp_p_o <= ctrl0_r[`F_RUN] && !ctrl0_r[`F_PAUSE] && (match_p || overflow); // see [R8]
        end
    end

    // output stage; pwm active while count below compare A, inactive from A up to period
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_r <= 1'b0;
        end else if (run_rise) begin
            out_r <= ctrl1_r[`F_INIT];
        end else if (mode == compact_timer_pkg::MODE_COMPARE && match_a && ctrl0_r[`F_RUN]) begin
            case (ctrl1_r[`F_IO_HI:`F_IO_LO]) // see [R11]
                2'h1: out_r <= 1'b0;
                2'h2: out_r <= 1'b1;
                2'h3: out_r <= !out_r;
                default: out_r <= out_r;
            endcase
        end else if (mode == compact_timer_pkg::MODE_PWM) begin
            case (ctrl1_r[`F_IO_HI:`F_IO_LO]) // see [R12]
                2'h0: out_r <= !ctrl1_r[`F_INIT];
                2'h1: out_r <= ctrl1_r[`F_INIT];
                2'h2: out_r <= (count_r < compare_a_value_r) ? ctrl1_r[`F_INIT] : !ctrl1_r[`F_INIT];
                default: out_r <= out_r;
            endcase
        end
    end

    // pins; polarity bit inverts the pair, pin functions decoded from the select fields
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_out_o <= 1'b0;
            timer_out_n_o <= 1'b1;
            port_pin7_timer_sel_o <= 1'b0;
            port_pin5_key_sel_o <= 1'b0;
            port_pin4_key_sel_o <= 1'b0;
            ext_irq_in_o <= 1'b0;
        end else begin
            timer_out_o <= out_r ^ ctrl1_r[`F_POL]; // see [R12]
            timer_out_n_o <= !(out_r ^ ctrl1_r[`F_POL]); // see [R12]
            port_pin7_timer_sel_o <= is_alt(pin_function_select_upper_r[`F_P7_HI:`F_P7_LO]); // see [R1] [R13]
            port_pin5_key_sel_o <= is_alt(pin_function_select_upper_r[`F_P5_HI:`F_P5_LO]); // see [R3]
            port_pin4_key_sel_o <= is_alt(pin_function_select_upper_r[`F_P4_HI:`F_P4_LO]); // see [R4]
            ext_irq_in_o <= input_source_select_r[`F_IRQPIN] ? port_pin6_i : port_pin0_i; // see [R6]
        end
    end

    // axi write channel capture; address and data accepted in either order
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_r[7:2] > `OFS_STATUS >> 2 || awaddr_r[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;

    // register writes; only byte lane 0 carries data
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl0_r <= `RST_BYTE;
            ctrl1_r <= `RST_BYTE;
            pin_function_select_upper_r <= `RST_BYTE;
            input_source_select_r <= `RST_BYTE;
            compare_a_value_r <= `CNT_ZERO;
        end else if (wr_fire && wstrb_r[0]) begin
            case (awaddr_r)
                `OFS_CTRL0: ctrl0_r <= wdata_r[7:0];
                `OFS_CTRL1: ctrl1_r <= wdata_r[7:0];
                `OFS_PIN_SEL: pin_function_select_upper_r <= wdata_r[7:0] & `PIN_SEL_MASK; // see [R2]
                `OFS_IN_SEL: input_source_select_r <= wdata_r[7:0] & `IN_SEL_MASK; // see [R6]
                `OFS_CMPA_HI: compare_a_value_r <= {wdata_r[1:0], byte_buf_r}; // see [R15]
                default: ;
            endcase
        end
    end

    // shared 8-bit low byte buffer; low write fills it, high read latches it
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            byte_buf_r <= `RST_BYTE;
        end else if (wr_fire && wstrb_r[0] && awaddr_r == `OFS_CMPA_LO) begin
            byte_buf_r <= wdata_r[7:0]; // see [R15] [R17]
        end else if (rd_fire && s_axi_araddr == `OFS_CNT_HI) begin
            byte_buf_r <= count_r[7:0]; // see [R16]
        end else if (rd_fire && s_axi_araddr == `OFS_CMPA_HI) begin
            byte_buf_r <= compare_a_value_r[7:0]; // see [R16]
        end
    end

    // read channel; one cycle from address to data
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr) // see [R14]
                `OFS_CTRL0: s_axi_rdata <= {24'h000000, ctrl0_r};
                `OFS_CTRL1: s_axi_rdata <= {24'h000000, ctrl1_r};
                `OFS_CNT_LO, `OFS_CMPA_LO: s_axi_rdata <= {24'h000000, byte_buf_r};
                `OFS_CNT_HI: s_axi_rdata <= {30'h00000000, count_r[9:8]};
                `OFS_CMPA_HI: s_axi_rdata <= {30'h00000000, compare_a_value_r[9:8]};
                `OFS_PIN_SEL: s_axi_rdata <= {24'h000000, pin_function_select_upper_r};
                `OFS_IN_SEL: s_axi_rdata <= {24'h000000, input_source_select_r};
                `OFS_STATUS: s_axi_rdata <= {21'h0, out_r, count_r};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

endmodule : compact_timer

// [testbench/compact_timer_props.sv]
// concurrent checks on the compact timer ports
`timescale 1ns/1ps
`include "compact_timer_map.svh"

module compact_timer_props (
    input wire logic clock_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic s_axi_awvalid, // write address valid
    input wire logic s_axi_awready, // write address ready
    input wire logic s_axi_wvalid, // write data valid
    input wire logic s_axi_wready, // write data ready
    input wire logic [1:0] s_axi_bresp, // write response
    input wire logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic [1:0] s_axi_rresp, // read response
    input wire logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic port_pin0_i, // pin 0 level
    input wire logic port_pin6_i, // pin 6 level
    input wire logic ext_irq_in_o, // routed interrupt input
    input wire logic timer_out_o, // primary output
    input wire logic timer_out_n_o // inverted output
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // both write channels taken at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    property p_wr_answer;
        s_wr_taken |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_rd_answer;
        s_rd_taken |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_r_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while busy");
    property p_w_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write taken while busy");
    // unmapped places answer an error and zero data
    property p_unmapped;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr > `OFS_STATUS)
            |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_inv;
        timer_out_n_o == !timer_out_o;
    endproperty
    a_inv: assert property (p_inv) else $error("outputs not inverse");
    // with equal pins the routed input must follow either way
    property p_irq_route;
        ($past(nrst_i) && $past(port_pin0_i) == $past(port_pin6_i)) |-> ext_irq_in_o == $past(port_pin0_i);
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("interrupt input wrong");
endmodule : compact_timer_props

bind compact_timer compact_timer_props i_props (.*);

// [testbench/pin_pulser.sv]
// pin-side model: bursts of pulses on a timer input pin
`timescale 1ns/1ps

module pin_pulser (
    input wire logic clock_i, // system clock
    input wire logic nrst_i, // async reset, active low
    input wire logic start_i, // load a burst
    input wire logic [3:0] n_i, // pulses in the burst
    output logic pin_o, // pulse train, low when idle
    output logic busy_o // burst under way
);
    logic [6:0] cnt_r; // eight cycles per pulse
    // four high, four low: slower than the synchroniser needs
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 7'h00;
        end else if (start_i) begin
            cnt_r <= {n_i, 3'h0};
        end else if (cnt_r != 7'h00) begin
            cnt_r <= cnt_r - 7'h01;
        end
    end
    assign pin_o = cnt_r[2];
    assign busy_o = cnt_r != 7'h00;
endmodule : pin_pulser

// [testbench/compact_timer_test.sv]
// register-level tests of the compact timer
`timescale 1ns/1ps
`include "compact_timer_map.svh"

module compact_timer_test;
    logic clock_i, nrst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, npulse;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic high_internal_clock_tick_i, sub_clock_tick_i, port_pin0_i, port_pin6_i, lvl6, tgt, go, pulse, busy;
    logic port_pin7_timer_sel_o, port_pin5_key_sel_o, port_pin4_key_sel_o, ext_irq_in_o;
    logic timer_out_o, timer_out_n_o, irq_cmp_a_o, irq_cmp_p_o;
    logic [9:0] v;
    int bad_count, n_compared, i, k;

    compact_timer i_dut (.*);
    pin_pulser i_pins (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(go), .n_i(npulse), .pin_o(pulse), .busy_o(busy));
    // pin 0 takes the pulses when tgt is set, else pin 6 does
    assign port_pin0_i = tgt & pulse;
    assign port_pin6_i = tgt ? lvl6 : pulse;

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // clock ticks kept moving so the divider paths see activity
    always @(posedge clock_i) begin
        high_internal_clock_tick_i <= ~high_internal_clock_tick_i;
        sub_clock_tick_i <= high_internal_clock_tick_i;
    end

    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // write: both channels offered, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock_i);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock_i); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock_i); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock_i); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // high byte first, then the buffered low byte
    task automatic rd10(input logic [7:0] a, output logic [9:0] r);
        logic [31:0] h, l;
        rd(a, h);
        rd(a - 8'h04, l);
        r = {h[1:0], l[7:0]};
    endtask : rd10

    // burst on one pin; the fixed tail covers the synchroniser latency
    task automatic pulses(input logic t, input logic [3:0] n);
        @(posedge clock_i);
        tgt <= t;
        npulse <= n;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        do @(posedge clock_i); while (busy === 1'b1);
        repeat (6) @(posedge clock_i);
    endtask : pulses

    initial begin
        {nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = 7'h00;
        {high_internal_clock_tick_i, sub_clock_tick_i, tgt, lvl6} = 4'hF;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, npulse} = 52'h0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(`OFS_PIN_SEL, rv);
        chk(rv, 32'h0);
        rd(`OFS_IN_SEL, rv);
        chk(rv, 32'h0);
        // every field value on the three routing fields
        for (i = 0; i < 4; i++) begin
            wr(`OFS_PIN_SEL, {24'h0, i[1:0], 2'h3, i[1:0], i[1:0]});
            rd(`OFS_PIN_SEL, rv);
            chk(rv, {24'h0, i[1:0], 2'h0, i[1:0], i[1:0]});
            chk(port_pin7_timer_sel_o, i == 3);
            chk(port_pin5_key_sel_o, i == 3);
            chk(port_pin4_key_sel_o, i == 3);
        end
        wr(`OFS_IN_SEL, 32'hFF);
        rd(`OFS_IN_SEL, rv);
        chk(rv, 32'h3);
        chk(ext_irq_in_o, 1'h1);
        wr(`OFS_IN_SEL, 32'h2);
        @(posedge clock_i);
        chk(ext_irq_in_o, 1'h0);
        // external clock, rising edges, pin 0 then pin 6, then falling edges on pin 6
        wr(`OFS_CTRL0, 32'h68);
        pulses(1'b1, 4'h3);
        pulses(1'b0, 4'h5);
        rd10(`OFS_CNT_HI, v);
        chk(v, 10'h003);
        wr(`OFS_IN_SEL, 32'h0);
        pulses(1'b0, 4'h5);
        rd10(`OFS_CNT_HI, v);
        chk(v, 10'h008);
        wr(`OFS_CTRL0, 32'h0);
        wr(`OFS_CTRL0, 32'h78);
        rd10(`OFS_CNT_HI, v);
        chk(v, 10'h000);
        pulses(1'b0, 4'h2);
        rd10(`OFS_CNT_HI, v);
        chk(v, 10'h002);
        // compare A pair goes through the shared buffer
        wr(`OFS_CTRL0, 32'h0);
        wr(`OFS_CMPA_LO, 32'hA5);
        wr(`OFS_CMPA_HI, 32'h2);
        rd10(`OFS_CMPA_HI, v);
        chk(v, 10'h2A5);
        wr(`OFS_CMPA_LO, 32'h3C);
        rd10(`OFS_CMPA_HI, v);
        chk(v, 10'h2A5);
        // compare A match drives high, then toggles
        wr(`OFS_CMPA_LO, 32'h5);
        wr(`OFS_CMPA_HI, 32'h0);
        wr(`OFS_CTRL1, 32'h21);
        wr(`OFS_CTRL0, 32'h18);
        for (k = 0; k < 50 && irq_cmp_a_o !== 1'b1; k++) @(posedge clock_i);
        chk(irq_cmp_a_o, 1'h1);
        for (k = 0; k < 4 && timer_out_o !== 1'b1; k++) @(posedge clock_i);
        chk(timer_out_o, 1'h1);
        chk(timer_out_n_o, 1'h0);
        wr(`OFS_CTRL1, 32'h31);
        for (k = 0; k < 40 && timer_out_o !== 1'b0; k++) @(posedge clock_i);
        chk(timer_out_o, 1'h0);
        // period 1: P matches every 129 counts
        wr(`OFS_CTRL0, 32'h0);
        wr(`OFS_CTRL1, 32'h0);
        wr(`OFS_CTRL0, 32'h19);
        for (k = 0; k < 300 && irq_cmp_p_o !== 1'b1; k++) @(posedge clock_i);
        chk(irq_cmp_p_o, 1'h1);
        @(posedge clock_i);
        for (k = 1; k < 300 && irq_cmp_p_o !== 1'b1; k++) @(posedge clock_i);
        chk(k >= 120 && k <= 140, 1'h1);
        // pwm, active high while count below compare A (5): five cycles high per period
        wr(`OFS_CTRL0, 32'h0);
        wr(`OFS_CTRL1, 32'hA8);
        wr(`OFS_CTRL0, 32'h19);
        for (k = 0; k < 300 && timer_out_o !== 1'b0; k++) @(posedge clock_i);
        for (k = 0; k < 300 && timer_out_o !== 1'b1; k++) @(posedge clock_i);
        chk(timer_out_n_o, 1'h0);
        for (k = 0; k < 300 && timer_out_o !== 1'b0; k++) @(posedge clock_i);
        chk(k, 5);
        rd(8'h40, rv);
        chk(rv, 32'h0);
        chk(rr, `RESP_SLVERR);
        conclude();
    end

    // whole run is under a thousand cycles
    initial begin
        #100us;
        bad_count++;
        conclude();
    end
endmodule : compact_timer_test
